// [pcpl_top.sv]
// Cycle-by-cycle pulse latch of a peak-current-mode PWM.
// Assumes the timing square wave, comparator trip and fault levels arrive asynchronously
// as pins; the link logic runs on link_clk_i, bookkeeping on clk_i.
`timescale 1ns/100ps
`include "pcpl_consts.svh"

module pcpl_top #(
  parameter int CNT_W = `PCPL_CNT_WIDTH
) (
  input wire logic clk_i, // System clock, 25 MHz
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic link_clk_i, // Clock of the link-facing logic
  input wire logic timing_input_i, // Timing square wave from the controller
  input wire logic trip_i, // Current-sense comparator trip, high ends pulse
  input wire logic supply_lockout_i, // Supply lockout condition, high active
  input wire logic overtemp_i, // Overtemperature condition, high active
  output logic drive_output_o, // Drive pin level
  output logic drive_output_oe_o, // Drive pin enable, high while driving
  output logic lockout_o, // Supply lockout seen
  output logic overtemp_o, // Overtemperature seen
  output logic [CNT_W-1:0] cycle_cnt_o, // Count of pulses ended by trip or timing rise
  output pcpl_pkg::pcpl_end_t end_reason_o // How the last pulse ended by trip or timing rise ended
);
  import pcpl_pkg::*;

  // ---------------- Reset release in both domains ----------------
  logic sys_rst_n;
  logic link_rst_n;

  pcpl_sync #(
    .WIDTH(1),
    .RST_VAL(`PCPL_RST_ACTIVE)
  ) u_sys_rst (
    .clk_i(clk_i),
    .rst_n_i(reset_n_i),
    .d_i(`PCPL_RST_FILL),
    .q_o(sys_rst_n)
  );

  pcpl_sync #(
    .WIDTH(1),
    .RST_VAL(`PCPL_RST_ACTIVE)
  ) u_link_rst (
    .clk_i(link_clk_i),
    .rst_n_i(reset_n_i),
    .d_i(`PCPL_RST_FILL),
    .q_o(link_rst_n)
  );

  // ---------------- System domain: fault levels ----------------
  logic [1:0] fault_pin_s;

  pcpl_sync #(
    .WIDTH(2)
  ) u_fault_sync (
    .clk_i(clk_i),
    .rst_n_i(sys_rst_n),
    .d_i({supply_lockout_i, overtemp_i}),
    .q_o(fault_pin_s)
  );

  // Registered levels also feed the link, so the link sees a glitch-free source
  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      lockout_o <= `PCPL_LEVEL_RESET;
      overtemp_o <= `PCPL_LEVEL_RESET;
    end
    else
    begin
      lockout_o <= fault_pin_s[1];
      overtemp_o <= fault_pin_s[0];
    end
  end

  // ---------------- Link domain: input synchronisers ----------------
  logic [1:0] pin_s;
  logic [1:0] fault_l;
  logic tim_s;
  logic trip_s;
  logic lock_l;
  logic ovt_l;
  logic shut_l;

  pcpl_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_i(link_clk_i),
    .rst_n_i(link_rst_n),
    .d_i({timing_input_i, trip_i}),
    .q_o(pin_s)
  );

  pcpl_sync #(
    .WIDTH(2)
  ) u_fault_link (
    .clk_i(link_clk_i),
    .rst_n_i(link_rst_n),
    .d_i({lockout_o, overtemp_o}),
    .q_o(fault_l)
  );

  assign tim_s = pin_s[1];
  assign trip_s = pin_s[0];
  assign lock_l = fault_l[1];
  assign ovt_l = fault_l[0];
  assign shut_l = lock_l | ovt_l;

  // ---------------- Link domain: edge detection ----------------
  logic tim_prev;
  logic tim_fall;
  logic tim_rise;

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      tim_prev <= `PCPL_LEVEL_RESET;
    else
      tim_prev <= tim_s;
  end

  assign tim_fall = tim_prev & ~tim_s;
  assign tim_rise = ~tim_prev & tim_s;

  // ---------------- Pulse latch ----------------
  // latch_qn high blocks the pulse. Trip resets it with priority over the
  // timing-high set, so a trip never gets lost to a coincident edge.
  logic latch_qn;

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      latch_qn <= `PCPL_LATCH_RESET;
    else if (shut_l)
      latch_qn <= `PCPL_LATCH_RESET;
    else if (trip_s)
      latch_qn <= `PCPL_LATCH_RESET;
    else if (tim_s)
      latch_qn <= ~`PCPL_LATCH_RESET;
  end

  // ---------------- Drive output stage ----------------
  logic drive_int;
  logic next_drive;
  logic next_oe;

  assign drive_int = tim_s | latch_qn;
  assign next_drive = ~drive_int & ~shut_l;
  assign next_oe = ovt_l ? `PCPL_OE_OFF : `PCPL_OE_ON;

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      drive_output_o <= `PCPL_DRIVE_OFF;
      drive_output_oe_o <= `PCPL_OE_ON;
    end
    else
    begin
      drive_output_o <= next_drive;
      drive_output_oe_o <= next_oe;
    end
  end

  // ---------------- Cycle phase tracking ----------------
  pcpl_phase_t phase;
  pcpl_phase_t next_phase;

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      PCPL_PH_HOLD:
        if (!shut_l)
          next_phase = PCPL_PH_WAIT;
      PCPL_PH_WAIT, PCPL_PH_OFF:
        if (tim_fall && !trip_s)
          next_phase = PCPL_PH_ON;
      PCPL_PH_ON:
        if (trip_s || tim_rise)
          next_phase = PCPL_PH_OFF;
    endcase
    if (shut_l)
      next_phase = PCPL_PH_HOLD;
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      phase <= PCPL_PH_HOLD;
    else
      phase <= next_phase;
  end

  // End reason is held stable until the next pulse ends, long after the
  // toggle has crossed, so the system side may sample it directly.
  pcpl_end_t end_reason_l;
  logic end_toggle;

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      end_reason_l <= PCPL_END_NONE;
      end_toggle <= `PCPL_LEVEL_RESET;
    end
    else if (phase == PCPL_PH_ON && next_phase == PCPL_PH_OFF)
    begin
      end_reason_l <= trip_s ? PCPL_END_TRIP : PCPL_END_MAX;
      end_toggle <= ~end_toggle;
    end
  end

  // ---------------- System domain: pulse bookkeeping ----------------
  logic end_toggle_s;
  logic end_toggle_prev;

  pcpl_sync #(
    .WIDTH(1)
  ) u_end_sync (
    .clk_i(clk_i),
    .rst_n_i(sys_rst_n),
    .d_i(end_toggle),
    .q_o(end_toggle_s)
  );

  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      end_toggle_prev <= `PCPL_LEVEL_RESET;
      cycle_cnt_o <= '0;
      end_reason_o <= PCPL_END_NONE;
    end
    else
    begin
      end_toggle_prev <= end_toggle_s;
      if (end_toggle_s != end_toggle_prev)
      begin
        cycle_cnt_o <= cycle_cnt_o + CNT_W'(`PCPL_CNT_STEP);
        end_reason_o <= end_reason_l;
      end
    end
  end

  // ---------------- Assertions (link domain) ----------------
  default clocking cb_link @(posedge link_clk_i);
  endclocking
  default disable iff (!link_rst_n);

  a_high_forces_low: assert property (tim_s |=> !drive_output_o)
    else $error("drive high after timing input high");

  a_low_follows_latch: assert property (
    !tim_s && !latch_qn && !shut_l |=> drive_output_o)
    else $error("drive not high with timing low and latch clear");

  a_fall_starts_pulse: assert property (
    tim_fall && !latch_qn && !shut_l |=> drive_output_o)
    else $error("falling timing edge did not start a pulse");

  a_start_keeps_latch: assert property (
    tim_fall && !latch_qn && !trip_s && !shut_l |=> !latch_qn)
    else $error("latch changed at cycle start without trip");

  a_drive_is_nor: assert property (
    drive_output_o |-> !$past(tim_s) && !$past(latch_qn) && !$past(shut_l))
    else $error("drive high while internal drive signal high");

  a_trip_ends_pulse: assert property (
    trip_s |=> latch_qn ##1 !drive_output_o)
    else $error("trip did not reset latch and end the pulse");

  a_trip_rise_low: assert property (
    latch_qn && !tim_s ##1 tim_rise |=> !drive_output_o [*2])
    else $error("timing rise after trip changed the drive");

  a_rise_max_duty: assert property (
    phase == PCPL_PH_ON && tim_rise && !trip_s |=> !drive_output_o ##0 phase == PCPL_PH_OFF)
    else $error("timing rise did not end the pulse");

  a_lockout_low: assert property (
    lock_l |=> !drive_output_o ##1 !drive_output_o)
    else $error("drive high during supply lockout");

  a_overtemp_hiz: assert property (
    ovt_l |=> !drive_output_oe_o && !drive_output_o)
    else $error("drive enabled during overtemperature");

  a_fault_exit_reset: assert property (
    $fell(shut_l) |-> latch_qn ##1 !drive_output_o)
    else $error("latch not reset on leaving a fault");

  c_trip_pulse: cover property (
    phase == PCPL_PH_ON ##1 phase == PCPL_PH_OFF && end_reason_l == PCPL_END_TRIP);
  c_max_duty_pulse: cover property (
    phase == PCPL_PH_ON ##1 phase == PCPL_PH_OFF && end_reason_l == PCPL_END_MAX);
  c_lockout: cover property (lock_l && !ovt_l);
  c_overtemp: cover property (ovt_l ##1 !drive_output_oe_o);

endmodule : pcpl_top

// [pcpl_consts.svh]
// Named constants of the peak current pulse latch.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef PCPL_CONSTS_SVH
`define PCPL_CONSTS_SVH

// Latch output after reset or shutdown: pulse blocked until a fresh cycle
`define PCPL_LATCH_RESET 1'b1
// Drive pin level and enable values
`define PCPL_DRIVE_OFF 1'b0
`define PCPL_DRIVE_ON 1'b1
`define PCPL_OE_ON 1'b1
`define PCPL_OE_OFF 1'b0
// Synchroniser fill value for reset release
`define PCPL_RST_FILL 1'b1
`define PCPL_RST_ACTIVE 1'b0
// Level-crossing reset values
`define PCPL_LEVEL_RESET 1'b0
// Pulse counter defaults
`define PCPL_CNT_WIDTH 16
`define PCPL_CNT_STEP 1

`endif

// [pcpl_pkg.sv]
// Types shared by the peak current pulse latch design.
// Assumes nothing of its surroundings.
package pcpl_pkg;

  // How the last pulse ended
  typedef enum logic [1:0] {
    PCPL_END_NONE,
    PCPL_END_TRIP,
    PCPL_END_MAX
  } pcpl_end_t;

  // Phase of the switching cycle on the link side
  typedef enum logic [1:0] {
    PCPL_PH_HOLD,
    PCPL_PH_WAIT,
    PCPL_PH_ON,
    PCPL_PH_OFF
  } pcpl_phase_t;

endpackage : pcpl_pkg

// [pcpl_sync.sv]
// Two flip-flop synchroniser, one lane per bit.
// Assumes each lane carries a slow level; multi-bit words are not kept coherent.
`timescale 1ns/100ps
`include "pcpl_consts.svh"

module pcpl_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = `PCPL_LEVEL_RESET
) (
  input wire logic clk_i, // Destination clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] d_i, // Level from the other domain
  output logic [WIDTH-1:0] q_o // Synchronised level
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= {WIDTH{RST_VAL}};
      q_o <= {WIDTH{RST_VAL}};
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : pcpl_sync

// [pcpl_ctrl_model.sv]
// Controller model: makes the timing square wave and the comparator trip on the link clock.
// Assumes the bench sets the phase lengths and holds them for whole periods.
`timescale 1ns/100ps

module pcpl_ctrl_model (
  input wire logic link_clk_i, // Link clock
  input wire logic run_i, // High runs the square wave
  input wire logic idle_i, // Timing level while stopped
  input wire logic [7:0] low_len_i, // Low phase in link cycles
  input wire logic [7:0] high_len_i, // High phase in link cycles
  input wire logic [7:0] trip_at_i, // Trip point after the fall, zero for none
  output logic timing_o, // Timing square wave
  output logic trip_o // Comparator trip
);
  logic [8:0] pos;
  logic [8:0] period;

  assign period = {1'b0, low_len_i} + {1'b0, high_len_i};

  always_ff @(posedge link_clk_i)
  begin
    if (!run_i || pos >= period - 9'h001)
      pos <= 9'h000;
    else
      pos <= pos + 9'h001;
  end

  // Low share of the period sets the maximum duty
  assign timing_o = run_i ? (pos >= {1'b0, low_len_i}) : idle_i;
  // Trip falls with the switch off, so the latch can re-arm while timing is high
  assign trip_o = run_i && (trip_at_i != 8'h00) && (pos >= {1'b0, trip_at_i})
    && (pos < {1'b0, low_len_i});
endmodule : pcpl_ctrl_model

// [peak_current_pwm_latch_test.sv]
// Self-checking bench of the pulse latch with a controller model on the link side.
// Assumes the two clocks are unrelated; the drive pin has a weak pull-down when released.
`timescale 1ns/100ps

module peak_current_pwm_latch_test;
  import pcpl_pkg::*;
  typedef struct packed {logic [7:0] low; logic [7:0] trip; logic [15:0] w; pcpl_end_t why;} pcpl_row_t;
  logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, run = 1'b0, idle = 1'b1;
  logic lockout = 1'b0, overtemp = 1'b0;
  logic [7:0] low_len = 8'h0C, trip_at = 8'h00;
  logic timing, trip, drive, oe, lock_seen, ot_seen, pin;
  logic [15:0] cnt, c0, w, bad;
  pcpl_end_t reason;
  int err_count = 0, checked = 0, ticks = 0;
  // Max duty rows and trip-ended rows; 18 low of 24 is the 75 percent case
  pcpl_row_t rows [5] = '{'{8'h12, 8'h00, 16'h0012, PCPL_END_MAX},
    '{8'h0C, 8'h05, 16'h0005, PCPL_END_TRIP}, '{8'h14, 8'h0F, 16'h000F, PCPL_END_TRIP},
    '{8'h08, 8'h00, 16'h0008, PCPL_END_MAX}, '{8'h10, 8'h0F, 16'h000F, PCPL_END_TRIP}};

  always #20 clk = ~clk;
  always #16 link_clk = ~link_clk;
  assign pin = oe ? drive : 1'b0;

  pcpl_ctrl_model i_ctrl (.link_clk_i(link_clk), .run_i(run), .idle_i(idle),
    .low_len_i(low_len), .high_len_i(8'h06), .trip_at_i(trip_at), .timing_o(timing),
    .trip_o(trip));

  pcpl_top i_dut (.clk_i(clk), .reset_n_i(reset_n), .link_clk_i(link_clk),
    .timing_input_i(timing), .trip_i(trip), .supply_lockout_i(lockout),
    .overtemp_i(overtemp), .drive_output_o(drive), .drive_output_oe_o(oe),
    .lockout_o(lock_seen), .overtemp_o(ot_seen), .cycle_cnt_o(cnt), .end_reason_o(reason));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task links(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask : links

  // Counts drive-high cycles over one period from the timing fall
  task measure(input logic [7:0] low);
    int k;
    w = 16'h0000;
    bad = 16'h0000;
    while (timing !== 1'b1) links(1);
    while (timing !== 1'b0) links(1);
    for (k = 0; k < low + 6; k++)
    begin
      if (drive === 1'b1) w++;
      if (k >= low + 4 && drive !== 1'b0) bad++;
      links(1);
    end
  endtask : measure

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 30000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    chk(16'({drive, oe, lock_seen, ot_seen}), 16'h0004);
    chk(cnt, 16'h0000);
    chk(16'(reason), 16'(PCPL_END_NONE));
    reset_n = 1'b1;
    links(8);
    foreach (rows[i])
    begin
      low_len = rows[i].low;
      trip_at = rows[i].trip;
      run = 1'b1;
      measure(low_len);
      measure(low_len);
      chk(16'(w + 1 >= rows[i].w && w <= rows[i].w + 1), 16'h1);
      chk(bad, 16'h0);
      links(4);
      chk(16'(reason), 16'(rows[i].why));
    end
    run = 1'b0;
    links(4);
    idle = 1'b0;
    links(6);
    chk(16'(drive), 16'h1);
    lockout = 1'b1;
    links(12);
    chk(16'({pin, oe, lock_seen}), 16'h0003);
    lockout = 1'b0;
    links(12);
    chk(16'(drive), 16'h0);
    overtemp = 1'b1;
    links(12);
    chk(16'({pin, oe, ot_seen}), 16'h0001);
    overtemp = 1'b0;
    links(12);
    chk(16'({drive, oe}), 16'h0001);
    // Both faults at once: the pin is released, overtemperature wins
    lockout = 1'b1;
    overtemp = 1'b1;
    links(12);
    chk(16'({pin, oe, lock_seen, ot_seen}), 16'h0003);
    lockout = 1'b0;
    overtemp = 1'b0;
    links(12);
    chk(16'({drive, oe}), 16'h0001);
    c0 = cnt;
    idle = 1'b1;
    links(4);
    idle = 1'b0;
    links(6);
    chk(16'(drive), 16'h1);
    idle = 1'b1;
    links(8);
    chk(16'(drive), 16'h0);
    chk(cnt, c0 + 16'h0001);
    chk(16'(reason), 16'(PCPL_END_MAX));
    // Reset in mid-pulse: outputs clear at once, no pulse without a fresh fall
    idle = 1'b0;
    links(6);
    chk(16'(drive), 16'h1);
    reset_n = 1'b0;
    #2;
    chk(16'({drive, oe, lock_seen, ot_seen}), 16'h0004);
    chk(cnt, 16'h0000);
    links(2);
    reset_n = 1'b1;
    links(8);
    chk(16'(drive), 16'h0);
    chk(16'(reason), 16'(PCPL_END_NONE));
    finish_test();
  end
endmodule : peak_current_pwm_latch_test
